// file: amis_core.v
// Operating mode tracking, event source collection and part identifier.
`include "amis_map.vh"

module amis_core #(
  parameter [7:0] PART_ID_VALUE = 8'h5c  // Arbitrary neutral identifier value.
) (
  input  wire       CLK_SYS,
  input  wire       RST_B,
  input  wire [7:0] REG_ADDR,
  input  wire       REG_RD,
  input  wire       REG_WR,
  input  wire [7:0] REG_WDATA,
  output reg  [7:0] REG_RDATA,
  output reg        REG_HIT,
  input  wire       ACTIVE_EN,
  input  wire       AUTOSLEEP_EN,
  input  wire [7:0] SLEEP_TIMEOUT_COUNT,
  input  wire       SLEEP_TICK,
  input  wire       ANY_INTERRUPT,
  input  wire       WAKE_EVENT,
  output wire [1:0] OPERATING_MODE_FIELD,
  output wire       LOW_SAMPLE_RATE_SEL,
  input  wire       TRANSIENT_EVENT_ACTIVE,
  input  wire       TRANSIENT_IRQ_EN,
  input  wire       TRANSIENT_SOURCE_RD,
  input  wire       ORIENTATION_CHANGED,
  input  wire       ORIENTATION_IRQ_EN,
  input  wire       ORIENTATION_STATUS_RD,
  input  wire       TAP_EVENT_ACTIVE,
  input  wire       TAP_IRQ_EN,
  input  wire       TAP_SOURCE_RD,
  input  wire       FREEFALL_EVENT_ACTIVE,
  input  wire       FREEFALL_IRQ_EN,
  input  wire       FREEFALL_SOURCE_RD,
  input  wire       ANY_AXIS_READY,
  input  wire       ANY_AXIS_OVERWRITE,
  input  wire       DATA_READY_IRQ_EN,
  input  wire       AXIS_DATA_RD,
  output wire [7:0] INTERRUPT_EVENT_SOURCES
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  reg  [1:0] mode_r;
  reg  [1:0] mode_nxt;
  reg  [8:0] idle_cnt_r;
  reg  [8:0] idle_cnt_nxt;
  reg        mode_event_r;
  reg        mode_event_nxt;
  reg  [7:0] rdata_nxt;
  reg        hit_nxt;
  wire [5:0] flag_cond;
  wire [5:0] flag_clr;
  wire [5:0] flags;
  wire       rd_mode;
  wire [8:0] timeout_ext;
  wire [7:0] mode_byte;
  wire [7:0] event_byte;

  // Address match used for both the read mux and the read side effects.
  function addr_is;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      addr_is = (addr == ofs);
    end
  endfunction

  // --------------------------------------------------------------------------
  // Operating mode machine
  // --------------------------------------------------------------------------
  assign timeout_ext = {1'b0, SLEEP_TIMEOUT_COUNT};

  // The idle counter runs on the sleep time base and restarts on any
  // interrupt; it stops one past the timeout, where the move to sleep clears it, so it cannot wrap back.
  always @*
  begin
    mode_nxt       = mode_r;
    idle_cnt_nxt   = idle_cnt_r;
    mode_event_nxt = 1'b0;
    case (mode_r)
      `AMIS_MODE_STANDBY:
      begin
        idle_cnt_nxt = `AMIS_CNT_ZERO;
        if (ACTIVE_EN)
          mode_nxt = `AMIS_MODE_WAKE;
      end
      `AMIS_MODE_WAKE:
      begin
        if (!ACTIVE_EN)
          mode_nxt = `AMIS_MODE_STANDBY;
        else if (ANY_INTERRUPT || !AUTOSLEEP_EN)
          idle_cnt_nxt = `AMIS_CNT_ZERO;
        else if (idle_cnt_r > timeout_ext)
        begin
          mode_nxt       = `AMIS_MODE_SLEEP;
          idle_cnt_nxt   = `AMIS_CNT_ZERO;
          mode_event_nxt = 1'b1;
        end
        else if (SLEEP_TICK)
          idle_cnt_nxt = idle_cnt_r + `AMIS_CNT_ONE;
      end
      `AMIS_MODE_SLEEP:
      begin
        idle_cnt_nxt = `AMIS_CNT_ZERO;
        if (!ACTIVE_EN)
          mode_nxt = `AMIS_MODE_STANDBY;
        else if (WAKE_EVENT || !AUTOSLEEP_EN)
        begin
          mode_nxt       = `AMIS_MODE_WAKE;
          mode_event_nxt = WAKE_EVENT;
        end
      end
      default:
      begin
        mode_nxt     = `AMIS_MODE_STANDBY;
        idle_cnt_nxt = `AMIS_CNT_ZERO;
      end
    endcase
  end

  // Mode state starts in standby.
  always @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      mode_r       <= `AMIS_MODE_STANDBY;
      idle_cnt_r   <= `AMIS_CNT_ZERO;
      mode_event_r <= 1'b0;
    end
    else
    begin
      mode_r       <= mode_nxt;
      idle_cnt_r   <= idle_cnt_nxt;
      mode_event_r <= mode_event_nxt;
    end
  end

  assign OPERATING_MODE_FIELD = mode_r;
  // Sleep picks the low sample rate, every other mode the high one.
  assign LOW_SAMPLE_RATE_SEL  = (mode_r == `AMIS_MODE_SLEEP);

  // --------------------------------------------------------------------------
  // Event flags
  // --------------------------------------------------------------------------
  assign rd_mode = REG_RD & addr_is(REG_ADDR, `AMIS_OFS_MODE);

  // Each flag except the sleep/wake one is gated by its own enable before the edge detector.
  assign flag_cond[`AMIS_IX_DRDY]      = (ANY_AXIS_READY | ANY_AXIS_OVERWRITE)
                                         & DATA_READY_IRQ_EN;
  assign flag_cond[`AMIS_IX_FFMT]      = FREEFALL_EVENT_ACTIVE
                                         & FREEFALL_IRQ_EN;
  assign flag_cond[`AMIS_IX_TAP]       = TAP_EVENT_ACTIVE
                                         & TAP_IRQ_EN;
  assign flag_cond[`AMIS_IX_ORIENT]    = ORIENTATION_CHANGED
                                         & ORIENTATION_IRQ_EN;
  assign flag_cond[`AMIS_IX_TRANSIENT] = TRANSIENT_EVENT_ACTIVE
                                         & TRANSIENT_IRQ_EN;
  assign flag_cond[`AMIS_IX_AUTOSLEEP] = mode_event_r;

  // Only the owning source read clears a flag; reading the event byte itself
  // or the general status does not, so polling never loses an event.
  assign flag_clr[`AMIS_IX_DRDY]      = AXIS_DATA_RD;
  assign flag_clr[`AMIS_IX_FFMT]      = FREEFALL_SOURCE_RD;
  assign flag_clr[`AMIS_IX_TAP]       = TAP_SOURCE_RD;
  assign flag_clr[`AMIS_IX_ORIENT]    = ORIENTATION_STATUS_RD;
  assign flag_clr[`AMIS_IX_TRANSIENT] = TRANSIENT_SOURCE_RD;
  assign flag_clr[`AMIS_IX_AUTOSLEEP] = rd_mode;

  genvar gi;
  generate
    for (gi = 0; gi < `AMIS_NFLAGS; gi = gi + 1)
    begin : g_flag
      amis_flag u_flag (
        .clk_sys (CLK_SYS),
        .rst_b   (RST_B),
        .cond    (flag_cond[gi]),
        .clr     (flag_clr[gi]),
        .flag    (flags[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Register images and read port
  // --------------------------------------------------------------------------
  assign event_byte = {flags[`AMIS_IX_AUTOSLEEP], 1'b0,
                       flags[`AMIS_IX_TRANSIENT], flags[`AMIS_IX_ORIENT],
                       flags[`AMIS_IX_TAP], flags[`AMIS_IX_FFMT],
                       1'b0, flags[`AMIS_IX_DRDY]};
  assign mode_byte  = {`AMIS_MODE_PAD, mode_r};
  assign INTERRUPT_EVENT_SOURCES = event_byte;

  // Read data is captured on the read strobe, so it shows the value before
  // any clear that the same read causes. Writes have no path to any state.
  always @*
  begin
    rdata_nxt = REG_RDATA;
    hit_nxt   = 1'b0;
    if (REG_RD)
    begin
      rdata_nxt = `AMIS_ZERO8;
      if (addr_is(REG_ADDR, `AMIS_OFS_MODE))
      begin
        rdata_nxt = mode_byte;
        hit_nxt   = 1'b1;
      end
      else if (addr_is(REG_ADDR, `AMIS_OFS_EVENTS))
      begin
        rdata_nxt = event_byte;
        hit_nxt   = 1'b1;
      end
      else if (addr_is(REG_ADDR, `AMIS_OFS_PART_ID))
      begin
        rdata_nxt = PART_ID_VALUE;
        hit_nxt   = 1'b1;
      end
    end
  end

  // REG_WR and REG_WDATA are deliberately unused: all three are read only.
  always @(posedge CLK_SYS or negedge RST_B)
  begin
    if (!RST_B)
    begin
      REG_RDATA <= `AMIS_ZERO8;
      REG_HIT   <= 1'b0;
    end
    else
    begin
      REG_RDATA <= rdata_nxt;
      REG_HIT   <= hit_nxt;
    end
  end

endmodule

// file: amis_core_monitor.sv
// Checker that watches the mode and event block at its ports.
module amis_mon #(
  parameter [7:0] PART_ID_VALUE = 8'h5c
) (
  input logic       CLK_SYS,
  input logic       RST_B,
  input logic [7:0] REG_ADDR,
  input logic       REG_RD,
  input logic [7:0] REG_RDATA,
  input logic       REG_HIT,
  input logic       ACTIVE_EN,
  input logic       TAP_EVENT_ACTIVE,
  input logic       TAP_IRQ_EN,
  input logic       TAP_SOURCE_RD,
  input logic       ANY_AXIS_READY,
  input logic       ANY_AXIS_OVERWRITE,
  input logic       AXIS_DATA_RD,
  input logic [1:0] OPERATING_MODE_FIELD,
  input logic       LOW_SAMPLE_RATE_SEL,
  input logic [7:0] INTERRUPT_EVENT_SOURCES
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_B);
  // Short names keep each property on one or two lines.
  wire [7:0] ev    = INTERRUPT_EVENT_SOURCES;
  wire [1:0] md    = OPERATING_MODE_FIELD;
  wire       tp    = TAP_EVENT_ACTIVE & TAP_IRQ_EN;
  wire       rd_id = REG_RD && REG_ADDR == 8'h0d;
  wire       rd_md = REG_RD && REG_ADDR == 8'h0b;

  AST_PAD: assert property (!ev[6] && !ev[1])
    else $error("Unused event bits are set.");
  AST_ID: assert property (rd_id |=>
    REG_HIT && REG_RDATA == PART_ID_VALUE) else $error("Bad identifier.");
  AST_MODE_RD: assert property (rd_md |=>
    REG_RDATA == {6'h00, $past(md)}) else $error("Bad mode read.");
  AST_TAP_SET: assert property (tp && !$past(tp) |=> ev[3])
    else $error("Tap flag missed.");
  AST_TAP_CLR: assert property (TAP_SOURCE_RD &&
    !(tp && !$past(tp)) |=> !ev[3]) else $error("Tap flag kept.");
  AST_DRDY_HOLD: assert property (ev[0] && !AXIS_DATA_RD |=> ev[0])
    else $error("Data-ready flag lost.");
  AST_DRDY_CLR: assert property (AXIS_DATA_RD &&
    !ANY_AXIS_READY && !ANY_AXIS_OVERWRITE |=> !ev[0])
    else $error("Data-ready flag kept.");
  AST_ASLP_CLR: assert property (rd_md && md == $past(md) |=> !ev[7])
    else $error("Sleep/wake flag kept after mode read.");
  AST_STBY: assert property (!ACTIVE_EN |=> md == 2'h0)
    else $error("Standby not reported.");
  AST_RATE: assert property (LOW_SAMPLE_RATE_SEL == (md == 2'h2))
    else $error("Sample rate select wrong.");
  C_SLEEP: cover property (md == 2'h1 ##1 md == 2'h2);
  C_TAP: cover property ($rose(ev[3]));
  C_ID: cover property (rd_id);
endmodule

bind amis_core amis_mon #(.PART_ID_VALUE(PART_ID_VALUE)) mon (
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .REG_HIT(REG_HIT), .ACTIVE_EN(ACTIVE_EN),
  .TAP_EVENT_ACTIVE(TAP_EVENT_ACTIVE), .TAP_IRQ_EN(TAP_IRQ_EN),
  .TAP_SOURCE_RD(TAP_SOURCE_RD), .ANY_AXIS_READY(ANY_AXIS_READY),
  .ANY_AXIS_OVERWRITE(ANY_AXIS_OVERWRITE), .AXIS_DATA_RD(AXIS_DATA_RD),
  .OPERATING_MODE_FIELD(OPERATING_MODE_FIELD),
  .LOW_SAMPLE_RATE_SEL(LOW_SAMPLE_RATE_SEL),
  .INTERRUPT_EVENT_SOURCES(INTERRUPT_EVENT_SOURCES));

// file: amis_flag.v
// Sticky event flag set on a rising condition and cleared by a read strobe.
module amis_flag (
  input  wire  clk_sys,
  input  wire  rst_b,
  input  wire  cond,
  input  wire  clr,
  output wire  flag
);

  // --------------------------------------------------------------------------
  // Edge detect and sticky hold
  // --------------------------------------------------------------------------
  reg  cond_prev_r;
  reg  flag_r;
  wire rise;
  wire flag_nxt;

  // A held condition sets the flag once; a new event needs a fresh edge.
  assign rise     = cond & ~cond_prev_r;
  // The set term wins so an event landing on the clearing read is kept.
  assign flag_nxt = rise | (flag_r & ~clr);
  assign flag     = flag_r;

  // Both registers start clear so no event is reported after reset.
  always @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cond_prev_r <= 1'b0;
      flag_r      <= 1'b0;
    end
    else
    begin
      cond_prev_r <= cond;
      flag_r      <= flag_nxt;
    end
  end

endmodule

// file: amis_host.sv
// Host model that reads and writes the block's registers.
module amis_host (
  input  logic       clk,
  output logic [7:0] addr,
  output logic       rd,
  output logic       wr,
  output logic [7:0] wdata,
  input  logic [7:0] rdata,
  input  logic       hit
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle bus at time zero.
  initial
  begin
    {addr, rd, wr, wdata} = '0;
  end
  // One access: strobe for a single edge, answer taken one cycle later.
  task automatic access(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q, output logic h);
    @(negedge clk);
    addr = a;
    wdata = d;
    rd = !w;
    wr = w;
    @(negedge clk);
    {rd, wr} = 2'b00;
    addr = ~a; // Released lines change so a stale value is never trusted.
    wdata = ~d;
    q = rdata;
    h = hit;
  endtask
endmodule

// file: amis_map.vh
// Register offsets, field positions and encodings of the mode and event block.
`ifndef AMIS_MAP_VH
`define AMIS_MAP_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define AMIS_OFS_MODE      8'h0b
`define AMIS_OFS_EVENTS    8'h0c
`define AMIS_OFS_PART_ID   8'h0d

// ----------------------------------------------------------------------------
// Operating mode encodings
// ----------------------------------------------------------------------------
`define AMIS_MODE_STANDBY  2'h0
`define AMIS_MODE_WAKE     2'h1
`define AMIS_MODE_SLEEP    2'h2

// ----------------------------------------------------------------------------
// Event flag positions in the event source byte
// ----------------------------------------------------------------------------
`define AMIS_BIT_AUTOSLEEP 7
`define AMIS_BIT_TRANSIENT 5
`define AMIS_BIT_ORIENT    4
`define AMIS_BIT_TAP       3
`define AMIS_BIT_FFMT      2
`define AMIS_BIT_DRDY      0

// Flag vector indices inside the block.
`define AMIS_NFLAGS        6
`define AMIS_IX_DRDY       0
`define AMIS_IX_FFMT       1
`define AMIS_IX_TAP        2
`define AMIS_IX_ORIENT     3
`define AMIS_IX_TRANSIENT  4
`define AMIS_IX_AUTOSLEEP  5

// ----------------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------------
`define AMIS_ZERO8         8'h00
`define AMIS_CNT_ZERO      9'h000
`define AMIS_CNT_ONE       9'h001
`define AMIS_FLAGS_ZERO    6'h00
`define AMIS_MODE_PAD      6'h00

`endif

// file: tb.sv
// Self-checking bench for the mode and event block.
`define CHK(n, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("CHECK FAILED %s exp %h got %h", n, e, g); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam [7:0] PID = 8'ha7; // Arbitrary identifier value.
  logic       clk, rst_b, act_en, asl_en, tick, anyi, wake, hit, lrs;
  logic       rdy, ovw, den, axrd, h, rd, wr;
  logic [3:0] ea, en, sclr;
  logic [7:0] tmo, q, addr, wdata, rdata, ev;
  logic [1:0] mode;
  int         checked, fail_count;

  amis_core #(.PART_ID_VALUE(PID)) dut (
    .CLK_SYS(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_RD(rd),
    .REG_WR(wr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_HIT(hit),
    .ACTIVE_EN(act_en), .AUTOSLEEP_EN(asl_en), .SLEEP_TIMEOUT_COUNT(tmo),
    .SLEEP_TICK(tick), .ANY_INTERRUPT(anyi), .WAKE_EVENT(wake),
    .OPERATING_MODE_FIELD(mode), .LOW_SAMPLE_RATE_SEL(lrs),
    .TRANSIENT_EVENT_ACTIVE(ea[0]), .TRANSIENT_IRQ_EN(en[0]),
    .TRANSIENT_SOURCE_RD(sclr[0]), .ORIENTATION_CHANGED(ea[1]),
    .ORIENTATION_IRQ_EN(en[1]), .ORIENTATION_STATUS_RD(sclr[1]),
    .TAP_EVENT_ACTIVE(ea[2]), .TAP_IRQ_EN(en[2]), .TAP_SOURCE_RD(sclr[2]),
    .FREEFALL_EVENT_ACTIVE(ea[3]), .FREEFALL_IRQ_EN(en[3]),
    .FREEFALL_SOURCE_RD(sclr[3]), .ANY_AXIS_READY(rdy),
    .ANY_AXIS_OVERWRITE(ovw), .DATA_READY_IRQ_EN(den),
    .AXIS_DATA_RD(axrd), .INTERRUPT_EVENT_SOURCES(ev));
  amis_host host (.clk(clk), .addr(addr), .rd(rd), .wr(wr),
    .wdata(wdata), .rdata(rdata), .hit(hit));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic give_verdict();
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Bounded wait for a mode; running out ends the run at once.
  task automatic wait_mode(input logic [1:0] m);
    for (int k = 0; k < 20 && mode !== m; k++)
      @(negedge clk);
    `CHK("mode", m, mode)
    if (mode !== m)
      give_verdict();
  endtask
  task automatic ticks(input int n);
    repeat (n)
    begin
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
      @(negedge clk);
    end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values, identifier, ignored writes and an unmapped read.
  task automatic t_regs();
    host.access(1'b0, 8'h0c, 8'h00, q, h);
    `CHK("events reset", 8'h00, q)
    for (int i = 0; i < 3; i++)
      host.access(1'b1, 8'h0b + 8'(i), 8'hff, q, h);
    host.access(1'b0, 8'h0b, 8'h00, q, h);
    `CHK("mode read", 8'h00, q)
    `CHK("mode hit", 1'b1, h)
    host.access(1'b0, 8'h0d, 8'h00, q, h);
    `CHK("identifier", PID, q)
    `CHK("events after write", 8'h00, ev)
    host.access(1'b0, 8'h0e, 8'h00, q, h);
    `CHK("unmapped hit", 1'b0, h)
    `CHK("unmapped data", 8'h00, q)
  endtask
  // Transient, orientation, tap and freefall: masked rise ignored, enabled rise sticks, read clears.
  task automatic t_flags();
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk);
      ea[i] = 1'b1;
      repeat (2) @(negedge clk);
      `CHK("masked", 8'h00, ev)
      ea[i] = 1'b0;
      en[i] = 1'b1;
      @(negedge clk);
      ea[i] = 1'b1;
      @(negedge clk);
      `CHK("flag set", 8'h01 << (5 - i), ev)
      sclr[i] = 1'b1;
      @(negedge clk);
      sclr[i] = 1'b0;
      repeat (2) @(negedge clk);
      `CHK("held after clear", 8'h00, ev)
      ea[i] = 1'b0;
    end
  endtask
  // Data ready survives other reads and clears only on the axis read.
  task automatic t_drdy();
    den = 1'b1;
    rdy = 1'b1;
    @(negedge clk);
    `CHK("ready set", 8'h01, ev)
    host.access(1'b0, 8'h0c, 8'h00, q, h);
    `CHK("events read", 8'h01, q)
    sclr = 4'hf;
    @(negedge clk);
    sclr = 4'h0;
    @(negedge clk);
    `CHK("ready kept", 8'h01, ev)
    {axrd, rdy} = 2'b10;
    @(negedge clk);
    {axrd, ovw} = 2'b01;
    `CHK("ready cleared", 8'h00, ev)
    @(negedge clk);
    `CHK("overwrite set", 8'h01, ev)
    {axrd, ovw} = 2'b10;
    @(negedge clk);
    axrd = 1'b0;
    `CHK("overwrite cleared", 8'h00, ev)
    @(negedge clk);
    {axrd, rdy} = 2'b11;
    @(negedge clk);
    `CHK("set wins", 8'h01, ev)
    rdy = 1'b0;
    @(negedge clk);
    axrd = 1'b0;
    `CHK("ready cleared late", 8'h00, ev)
  endtask
  // Wake, idle timeout into sleep, wake event, back to standby.
  task automatic t_sleep();
    {tmo, asl_en, anyi, act_en} = {8'h02, 3'b111};
    wait_mode(2'h1);
    ticks(5);
    anyi = 1'b0;
    ticks(2);
    repeat (3) @(negedge clk);
    `CHK("still awake", 2'h1, mode)
    ticks(1);
    wait_mode(2'h2);
    `CHK("low rate", 1'b1, lrs)
    repeat (3) @(negedge clk);
    `CHK("sleep event", 1'b1, ev[7])
    host.access(1'b0, 8'h0b, 8'h00, q, h);
    `CHK("sleep code", 8'h02, q)
    `CHK("event cleared", 1'b0, ev[7])
    wake = 1'b1;
    @(negedge clk);
    wake = 1'b0;
    wait_mode(2'h1);
    `CHK("high rate", 1'b0, lrs)
    repeat (3) @(negedge clk);
    `CHK("wake event", 1'b1, ev[7])
    act_en = 1'b0;
    wait_mode(2'h0);
  endtask

  // ----------------------------------------
  // Clock, reset and sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    {act_en, asl_en, tick, anyi, wake, rdy, ovw, den, axrd} = '0;
    {ea, en, sclr, tmo} = '0;
    {checked, fail_count} = '0;
    rst_b = 1'b0;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    t_regs();
    t_flags();
    t_drdy();
    t_sleep();
    give_verdict();
  end
endmodule
